//--- pkg/hsf_pkg.sv
package hsf_pkg;
  // Command codes
  localparam logic [7:0] CMD_OPERATION = 8'h03;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h04;
  localparam logic [7:0] CMD_OT_FAULT = 8'h4F;
  localparam logic [7:0] CMD_OT_WARN = 8'h51;
  localparam logic [7:0] CMD_SUMMARY = 8'h79;
  localparam logic [7:0] CMD_INPUT = 8'h7C;
  localparam logic [7:0] CMD_MISC = 8'h7F;
  localparam logic [7:0] CMD_VENDOR = 8'h80;
  localparam logic [7:0] CMD_TEMP = 8'h8D;
  localparam logic [7:0] CMD_ALERT_MASK = 8'hD8;
  localparam logic [7:0] CMD_SETUP = 8'hD9;
  localparam logic [7:0] CMD_DIAG = 8'hE1;
  // Bus address, arbitrary value
  localparam logic [6:0] SLAVE_ADDR = 7'h40;
  // Operation values
  localparam logic [7:0] OP_OFF = 8'h00;
  localparam logic [7:0] OP_ON = 8'h80;
  localparam int OP_ON_BIT = 7;
  // Fault source index, shared by flags and alert mask
  localparam int FLG_OC = 0;
  localparam int FLG_UV = 1;
  localparam int FLG_OV = 2;
  localparam int FLG_BRK = 3;
  localparam int FLG_OTW = 4;
  localparam int FLG_OTF = 5;
  localparam int FLG_PRESET = 6;
  localparam int NFLG = 7;
  localparam logic [NFLG-1:0] FLG_RESET = 7'h40;
  // Status field positions
  localparam int SUM_INPUT = 13;
  localparam int SUM_PG_N = 11;
  localparam int INP_OV = 7;
  localparam int INP_UV = 4;
  localparam int INP_OC = 2;
  localparam int MISC_BRK = 1;
  localparam int VND_BRK = 4;
  localparam int VND_PRESET = 0;
  localparam int DG_UV = 13;
  localparam int DG_OV = 12;
  localparam int DG_OC = 11;
  localparam int DG_OTF = 9;
  localparam int DG_OTW = 8;
  localparam int DG_BRK = 7;
  localparam int DG_LATCH = 5;
  localparam int DG_PG = 3;
  // Setup override fields
  localparam int SET_LIM_EN = 7;
  localparam int SET_LIM_VAL = 6;
  localparam int SET_BRK_EN = 5;
  localparam int SET_BRK_VAL = 4;
  // Reset values
  localparam logic [7:0] OP_RESET = 8'h80;
  localparam logic [15:0] OT_WARN_RESET = 16'h007D;
  localparam logic [15:0] OT_FAULT_RESET = 16'h0096;
  localparam logic [15:0] MASK_RESET = 16'h0000;
  localparam logic [7:0] SETUP_RESET = 8'h00;
  // Timing
  localparam int CLK_FREQ_HZ = 20_000_000;
  localparam int TEMP_PERIOD_US = 1000;
  localparam int TEMP_PERIOD_CYC = CLK_FREQ_HZ / 1_000_000 * TEMP_PERIOD_US;
  typedef struct packed {
    logic limit_select_pin;
    logic current_limit;
    logic power_limit;
    logic breaker_trip;
    logic undervoltage_enable_in;
    logic overvoltage_in;
    logic feedback_in;
    logic timer_top;
  } hsf_cmp_t;
  typedef enum logic [2:0] {
    BUS_IDLE, BUS_RX, BUS_ACK_WAIT, BUS_ACK, BUS_TX, BUS_MACK
  } hsf_bus_st_t;
endpackage

//--- src/hsf_fault_status.sv
// What this block does
// - Current limiting runs the fault timer; normal operation returns when it ends.
// - Limiting past timeout sets input overcurrent, input summary, diagnostic flags, alert.
// - Alert mask suppresses the alert per fault source; host programs it.
// - Setup register can override the pin-selected current-limit threshold.
// - Breaker trip above 1.94x or 3.87x turns switch off fast, starts timeout.
// - Below breaker threshold, fast turn-off releases to the limit loops.
// - Fault timer reaching top while limiting turns the pass switch off.
// - Breaker event sets misc, vendor and diagnostic flags and alert unless masked.
// - Setup register can override the strapped breaker configuration.
// - Power limit regulates the switch and runs the fault timer.
// - Power limiting past timeout sets the same flags as current limit.
// - Switch off while undervoltage input low; on only after insertion delay.
// - Undervoltage after power-up sets summary, input and diagnostic flags, alert.
// - Switch off while overvoltage input high; re-enabled when it drops.
// - Overvoltage sets input, summary and diagnostic flags and alert unless masked.
// - Power-good goes high when feedback exceeds its threshold.
// - Power-good forced low on undervoltage or overvoltage, whatever feedback.
// - Power-good state readable in summary and diagnostic words.
// - Temperature sampled every millisecond; latest value returned on read command.
// - Default alert above 125 C, switch off above 150 C; limits programmable.
// - Writing 0 then 80h to operation resets faults and re-enables.
// - After reset alert asserts and preset flag holds until clear-faults or the 0 then 80h operation sequence.
module hsf_fault_status
  import hsf_pkg::*;
#(
  parameter int TEMP_PERIOD = TEMP_PERIOD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Comparator results and strap
  input wire hsf_cmp_t cmp_in,
  // SMBus link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic alert_out,
  output logic alert_oe,
  // Temperature converter
  output logic temp_start,
  input wire logic temp_valid,
  input wire logic [15:0] temp_value,
  // Pass switch and indicators
  output logic gate_on,
  output logic fast_turn_off,
  output logic timer_run,
  output logic overcurrent_threshold,
  output logic fast_trip_breaker_ratio,
  output logic power_good_out
);

  localparam int NSYNC = $bits(hsf_cmp_t) + 2;
  localparam int TW = $clog2(TEMP_PERIOD);

  logic rst_meta_n;
  logic rst_sync_n;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync_q;
  hsf_cmp_t cmp;
  logic scl_q;
  logic sda_q;
  logic scl_d;
  logic sda_d;
  logic brk_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  hsf_bus_st_t st;
  logic [2:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] rx_sh;
  logic [7:0] rx_byte;
  logic [7:0] tx_sh;
  logic [7:0] cmd;
  logic [7:0] wr_lo;
  logic rd;
  logic tx_hi;
  logic m_ack;
  logic rx_done;
  logic [15:0] rd_word;
  logic [7:0] op_ctrl;
  logic [15:0] ot_fault_lim;
  logic [15:0] ot_warn_lim;
  logic [15:0] alert_mask;
  logic [7:0] setup;
  logic [15:0] temp_reading;
  logic [TW-1:0] tcnt;
  logic zero_seen;
  logic reset_seq;
  logic clr_faults;
  logic ins_done;
  logic latched_off;
  logic limiting;
  logic timeout_ev;
  logic [NFLG-1:0] flg;
  logic [NFLG-1:0] flg_set;
  logic flg_clr;

  // Reset release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Pins and the bus clock come from outside the domain
  assign raw_in = {cmp_in, scl_in, sda_in};
  generate
    for (genvar i = 0; i < NSYNC; i++) begin : g_sync
      logic meta;
      logic q;
      always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          meta <= (i < 2);
          q <= (i < 2);
        end else begin
          meta <= raw_in[i];
          q <= meta;
        end
      end
      assign sync_q[i] = q;
    end
  endgenerate
  assign cmp = sync_q[NSYNC-1:2];
  assign scl_q = sync_q[1];
  assign sda_q = sync_q[0];

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      // Bus lines idle high; a low reset value would fake an edge
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      brk_d <= 1'b0;
    end else begin
      scl_d <= scl_q;
      sda_d <= sda_q;
      brk_d <= cmp.breaker_trip;
    end
  end

  // Start and stop need the clock stable high for two samples
  assign scl_rise = scl_q & ~scl_d;
  assign scl_fall = ~scl_q & scl_d;
  assign bus_start = scl_q & scl_d & sda_d & ~sda_q;
  assign bus_stop = scl_q & scl_d & ~sda_d & sda_q;
  assign rx_byte = {rx_sh[6:0], sda_q};
  assign rx_done = (st == BUS_RX) & scl_rise & (bit_cnt == 3'h7);

  // Bus slave, open drain: only the enable moves
  assign sda_out = 1'b0;
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      st <= BUS_IDLE;
      bit_cnt <= 3'h0;
      byte_idx <= 2'h0;
      rx_sh <= 8'h00;
      tx_sh <= 8'h00;
      cmd <= 8'h00;
      wr_lo <= 8'h00;
      rd <= 1'b0;
      tx_hi <= 1'b0;
      m_ack <= 1'b0;
      sda_oe <= 1'b0;
    end else if (bus_start) begin
      st <= BUS_RX;
      bit_cnt <= 3'h0;
      byte_idx <= 2'h0;
      sda_oe <= 1'b0;
    end else if (bus_stop) begin
      st <= BUS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      unique case (st)
        BUS_IDLE: begin
        end
        BUS_RX: begin
          if (scl_rise) begin
            rx_sh <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
          end
          if (rx_done) begin
            if (byte_idx != 2'h3) begin
              byte_idx <= byte_idx + 2'h1;
            end
            if (byte_idx == 2'h0) begin
              rd <= rx_byte[0];
            end
            if (byte_idx == 2'h1) begin
              cmd <= rx_byte;
            end
            if (byte_idx == 2'h2) begin
              wr_lo <= rx_byte;
            end
            // Another address stays silent
            if (byte_idx == 2'h0 && rx_byte[7:1] != SLAVE_ADDR) begin
              st <= BUS_IDLE;
            end else begin
              st <= BUS_ACK_WAIT;
            end
          end
        end
        BUS_ACK_WAIT: begin
          if (scl_fall) begin
            sda_oe <= 1'b1;
            st <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 3'h0;
            if (rd) begin
              tx_sh <= rd_word[7:0];
              sda_oe <= ~rd_word[7];
              tx_hi <= 1'b1;
              st <= BUS_TX;
            end else begin
              sda_oe <= 1'b0;
              st <= BUS_RX;
            end
          end
        end
        BUS_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 3'h7) begin
              sda_oe <= 1'b0;
              st <= BUS_MACK;
            end else begin
              bit_cnt <= bit_cnt + 3'h1;
              tx_sh <= {tx_sh[6:0], 1'b0};
              sda_oe <= ~tx_sh[6];
            end
          end
        end
        BUS_MACK: begin
          if (scl_rise) begin
            m_ack <= ~sda_q;
          end
          if (scl_fall) begin
            if (m_ack) begin
              bit_cnt <= 3'h0;
              tx_sh <= tx_hi ? rd_word[15:8] : 8'h00;
              sda_oe <= tx_hi ? ~rd_word[15] : 1'b0;
              tx_hi <= 1'b0;
              st <= BUS_TX;
            end else begin
              st <= BUS_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Read data, low byte first
  always_comb begin
    rd_word = 16'h0000;
    unique case (cmd)
      CMD_OPERATION: rd_word[7:0] = op_ctrl;
      CMD_OT_FAULT: rd_word = ot_fault_lim;
      CMD_OT_WARN: rd_word = ot_warn_lim;
      CMD_SUMMARY: begin
        rd_word[SUM_INPUT] = flg[FLG_OC] | flg[FLG_UV] | flg[FLG_OV];
        rd_word[SUM_PG_N] = ~power_good_out;
      end
      CMD_INPUT: begin
        rd_word[INP_OV] = flg[FLG_OV];
        rd_word[INP_UV] = flg[FLG_UV];
        rd_word[INP_OC] = flg[FLG_OC];
      end
      CMD_MISC: rd_word[MISC_BRK] = flg[FLG_BRK];
      CMD_VENDOR: begin
        rd_word[VND_BRK] = flg[FLG_BRK];
        rd_word[VND_PRESET] = flg[FLG_PRESET];
      end
      CMD_TEMP: rd_word = temp_reading;
      CMD_ALERT_MASK: rd_word = alert_mask;
      CMD_SETUP: rd_word[7:0] = setup;
      CMD_DIAG: begin
        rd_word[DG_UV] = flg[FLG_UV];
        rd_word[DG_OV] = flg[FLG_OV];
        rd_word[DG_OC] = flg[FLG_OC];
        rd_word[DG_OTF] = flg[FLG_OTF];
        rd_word[DG_OTW] = flg[FLG_OTW];
        rd_word[DG_BRK] = flg[FLG_BRK];
        rd_word[DG_LATCH] = latched_off;
        rd_word[DG_PG] = power_good_out;
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // Host-written registers
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      op_ctrl <= OP_RESET;
      ot_fault_lim <= OT_FAULT_RESET;
      ot_warn_lim <= OT_WARN_RESET;
      alert_mask <= MASK_RESET;
      setup <= SETUP_RESET;
    end else if (rx_done && !rd && byte_idx == 2'h2) begin
      if (cmd == CMD_OPERATION) begin
        op_ctrl <= rx_byte;
      end
      if (cmd == CMD_SETUP) begin
        setup <= rx_byte;
      end
    end else if (rx_done && !rd && byte_idx == 2'h3) begin
      if (cmd == CMD_OT_FAULT) begin
        ot_fault_lim <= {rx_byte, wr_lo};
      end
      if (cmd == CMD_OT_WARN) begin
        ot_warn_lim <= {rx_byte, wr_lo};
      end
      if (cmd == CMD_ALERT_MASK) begin
        alert_mask <= {rx_byte, wr_lo};
      end
    end
  end

  // Off then on recovers from a spurious fault
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      zero_seen <= 1'b0;
      reset_seq <= 1'b0;
      clr_faults <= 1'b0;
    end else begin
      reset_seq <= 1'b0;
      clr_faults <= rx_done & ~rd & (byte_idx == 2'h1) & (rx_byte == CMD_CLEAR_FAULTS);
      if (rx_done && !rd && byte_idx == 2'h2 && cmd == CMD_OPERATION) begin
        zero_seen <= (rx_byte == OP_OFF);
        reset_seq <= zero_seen & (rx_byte == OP_ON);
      end
    end
  end

  // Temperature sampling
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      tcnt <= '0;
      temp_start <= 1'b0;
      temp_reading <= 16'h0000;
    end else begin
      temp_start <= (tcnt == TW'(TEMP_PERIOD - 1));
      if (tcnt == TW'(TEMP_PERIOD - 1)) begin
        tcnt <= '0;
      end else begin
        tcnt <= tcnt + TW'(1);
      end
      if (temp_valid) begin
        temp_reading <= temp_value;
      end
    end
  end

  // Fault supervision
  assign limiting = cmp.current_limit | cmp.power_limit;
  // The insertion delay ends on the first timer top; it is no fault
  assign timeout_ev = ins_done & cmp.timer_top & (limiting | cmp.breaker_trip);

  always_comb begin
    flg_set = '0;
    flg_set[FLG_OC] = timeout_ev;
    flg_set[FLG_UV] = ins_done & ~cmp.undervoltage_enable_in;
    flg_set[FLG_OV] = cmp.overvoltage_in;
    flg_set[FLG_BRK] = cmp.breaker_trip & ~brk_d;
    flg_set[FLG_OTW] = temp_reading > ot_warn_lim;
    flg_set[FLG_OTF] = temp_reading > ot_fault_lim;
  end
  assign flg_clr = clr_faults | reset_seq;

  // Sticky flags; a set in the clearing cycle wins
  generate
    for (genvar i = 0; i < NFLG; i++) begin : g_flag
      always_ff @(posedge sys_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          flg[i] <= FLG_RESET[i];
        end else if (flg_set[i]) begin
          flg[i] <= 1'b1;
        end else if (flg_clr) begin
          flg[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      ins_done <= 1'b0;
      latched_off <= 1'b0;
    end else begin
      if (cmp.timer_top) begin
        ins_done <= 1'b1;
      end
      // Pulling the enable input low restarts a latched switch
      if (timeout_ev) begin
        latched_off <= 1'b1;
      end else if (reset_seq || !cmp.undervoltage_enable_in) begin
        latched_off <= 1'b0;
      end
    end
  end

  // Pass switch drive, thresholds and indicators
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gate_on <= 1'b0;
      fast_turn_off <= 1'b0;
      timer_run <= 1'b0;
      overcurrent_threshold <= 1'b0;
      fast_trip_breaker_ratio <= 1'b0;
      power_good_out <= 1'b0;
      alert_oe <= 1'b0;
    end else begin
      gate_on <= ins_done & cmp.undervoltage_enable_in & ~cmp.overvoltage_in
        & ~latched_off & ~flg[FLG_OTF] & op_ctrl[OP_ON_BIT]
        & ~cmp.breaker_trip;
      fast_turn_off <= cmp.breaker_trip;
      timer_run <= ~ins_done | limiting | cmp.breaker_trip;
      overcurrent_threshold <= setup[SET_LIM_EN] ? setup[SET_LIM_VAL]
        : cmp.limit_select_pin;
      fast_trip_breaker_ratio <= setup[SET_BRK_EN] ? setup[SET_BRK_VAL]
        : cmp.limit_select_pin;
      power_good_out <= cmp.feedback_in & cmp.undervoltage_enable_in
        & ~cmp.overvoltage_in;
      alert_oe <= |(flg & ~alert_mask[NFLG-1:0]);
    end
  end
  // Alert pulls low only; the enable carries the state
  assign alert_out = 1'b0;

endmodule

//--- verif/hsf_fault_status_properties.sv
module hsf_fault_status_properties
  import hsf_pkg::*;
#(
  parameter int TEMP_PERIOD = TEMP_PERIOD_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched pins
  input wire hsf_cmp_t cmp_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic alert_out,
  input wire logic alert_oe,
  input wire logic temp_start,
  input wire logic gate_on,
  input wire logic fast_turn_off,
  input wire logic timer_run,
  input wire logic power_good_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] up;
  logic [15:0] gap;
  logic [7:0] quiet;
  logic sda_q;
  logic seen;
  logic live;
  assign live = (up == 4'hF);
  // Synchronisers still hold reset values just after release
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 4'h0;
    end else if (!live) begin
      up <= up + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap <= 16'h0000;
      seen <= 1'b0;
    end else begin
      gap <= temp_start ? 16'h0000 : gap + 16'h0001;
      seen <= seen | temp_start;
    end
  end
  // Flags only clear through bus traffic, so the data line moved recently
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_q <= 1'b1;
      quiet <= 8'h00;
    end else begin
      sda_q <= sda_in;
      quiet <= (sda_in != sda_q) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_limit_top;
    gate_on && cmp_in.timer_top && (cmp_in.current_limit || cmp_in.power_limit);
  endsequence
  sequence s_off_soon;
    ##[1:6] !gate_on;
  endsequence
  property p_pg_good;
    live |-> power_good_out == ($past(cmp_in.feedback_in, 3)
      && $past(cmp_in.undervoltage_enable_in, 3) && !$past(cmp_in.overvoltage_in, 3));
  endproperty
  a_pg_good: assert property (p_pg_good) else $error("power good mismatch");
  property p_brk;
    live |-> fast_turn_off == $past(cmp_in.breaker_trip, 3);
  endproperty
  a_brk: assert property (p_brk) else $error("fast turn-off mismatch");
  property p_gate_off;
    !cmp_in.undervoltage_enable_in || cmp_in.overvoltage_in |-> ##3 !gate_on;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate on outside window");
  property p_timer;
    live && gate_on && !cmp_in.timer_top && (cmp_in.current_limit || cmp_in.power_limit)
      |-> ##3 timer_run;
  endproperty
  a_timer: assert property (p_timer) else $error("fault timer idle while limiting");
  property p_timeout;
    s_limit_top |-> s_off_soon;
  endproperty
  a_timeout: assert property (p_timeout) else $error("gate stays on after timeout");
  property p_alert_hold;
    $fell(alert_oe) |-> quiet < 8'd60;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("alert dropped by itself");
  property p_wires;
    !sda_out && !alert_out;
  endproperty
  a_wires: assert property (p_wires) else $error("open drain drives high");
  property p_temp;
    seen |-> (temp_start ? gap == 16'(TEMP_PERIOD - 1) : gap < 16'(TEMP_PERIOD - 1));
  endproperty
  a_temp: assert property (p_temp) else $error("sample period wrong");
endmodule

//--- verif/hsf_fault_status_tb.sv
module hsf_fault_status_tb
  import hsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TP = 50;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  hsf_cmp_t cmp_in;
  logic scl, host_low, sda_wire, ack, ts_seen = 1'b0, temp_valid = 1'b0;
  logic sda_out, sda_oe, alert_out, alert_oe, temp_start, gate_on, fast_turn_off, timer_run;
  logic overcurrent_threshold, fast_trip_breaker_ratio, power_good_out;
  logic [15:0] rd, mask, tval = 16'h0019;
  logic [31:0] lfsr = 32'h00017C16;
  logic [15:0] exp_q[$], got_q[$];
  logic [7:0] cmds[6] = '{CMD_OPERATION, CMD_OT_WARN, CMD_OT_FAULT, CMD_ALERT_MASK,
    CMD_SETUP, 8'h20};
  logic [15:0] dflt[6] = '{16'h0080, OT_WARN_RESET, OT_FAULT_RESET, MASK_RESET, 16'h0000,
    16'h0000};
  int n_fail = 0;
  int num_checks = 0;
  event ev;
  assign sda_wire = !(host_low || sda_oe);
  always #25 sys_clk = ~sys_clk;
  always @(negedge sys_clk) ts_seen = temp_start;
  always @(posedge sys_clk) #2 temp_valid = ts_seen;
  hsf_host_model i_hsf_host_model (.scl, .sda_low(host_low), .sda_wire);
  hsf_fault_status #(.TEMP_PERIOD(TP)) i_hsf_fault_status (.sys_clk, .rst_n, .cmp_in,
    .scl_in(scl), .sda_in(sda_wire), .sda_out, .sda_oe, .alert_out, .alert_oe, .temp_start,
    .temp_valid, .temp_value(tval), .gate_on, .fast_turn_off, .timer_run,
    .overcurrent_threshold, .fast_trip_breaker_ratio, .power_good_out);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    exp_q.push_back(e);
    got_q.push_back(g);
    ->ev;
  endtask
  always @(ev) begin
    while (got_q.size() > 0) begin
      num_checks++;
      if (got_q[0] !== exp_q[0]) begin
        n_fail++;
        $display("BAD %0t got %h expected %h", $time, got_q[0], exp_q[0]);
      end
      void'(got_q.pop_front());
      void'(exp_q.pop_front());
    end
  end
  task automatic rdx(input logic [7:0] c, input logic [15:0] e);
    i_hsf_host_model.rd(c, rd, ack);
    chk(e, (ack === 1'b1) ? rd : 'x);
  endtask
  task automatic wrx(input logic [7:0] c, input logic [15:0] d, input int nb);
    i_hsf_host_model.wr(c, d, nb, ack);
    chk(16'h0001, 16'(ack));
    cyc(4);
  endtask
  task automatic clr();
    wrx(CMD_CLEAR_FAULTS, 16'h0000, 0);
    cyc(4);
  endtask
  task automatic lim(input logic on, input int k);
    cmp_in.current_limit = on && (k == 0);
    cmp_in.power_limit = on && (k == 1);
    cyc(6);
  endtask
  task automatic final_report();
    // Let the monitor drain the last notes first
    #1;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #3ms;
    n_fail++;
    $display("BAD %0t run did not finish", $time);
    final_report();
  end
  initial begin
    cmp_in = '0;
    cmp_in.limit_select_pin = 1'b1;
    cmp_in.undervoltage_enable_in = 1'b1;
    cmp_in.feedback_in = 1'b1;
    repeat (5) @(posedge sys_clk);
    #2 rst_n = 1'b1;
    cyc(12);
    chk(16'h0001, 16'({gate_on, alert_oe}));
    rdx(CMD_VENDOR, 16'h0001);
    for (int i = 0; i < 6; i++) rdx(cmds[i], dflt[i]);
    cmp_in.timer_top = 1'b1;
    cyc(2);
    cmp_in.timer_top = 1'b0;
    cyc(6);
    chk(16'h0003, 16'({gate_on, power_good_out}));
    clr();
    chk(16'h0000, 16'(alert_oe));
    rdx(CMD_VENDOR, 16'h0000);
    chk(16'h0003, 16'({overcurrent_threshold, fast_trip_breaker_ratio}));
    cmp_in.limit_select_pin = 1'b0;
    cyc(6);
    chk(16'h0000, 16'({overcurrent_threshold, fast_trip_breaker_ratio}));
    wrx(CMD_SETUP, 16'h00F0, 1);
    chk(16'h0003, 16'({overcurrent_threshold, fast_trip_breaker_ratio}));
    wrx(CMD_SETUP, 16'h00C0, 1);
    chk(16'h0002, 16'({overcurrent_threshold, fast_trip_breaker_ratio}));
    wrx(CMD_SETUP, 16'h0000, 1);
    wrx(CMD_INPUT, 16'h00FF, 1);
    rdx(CMD_INPUT, 16'h0000);
    // Random mask, but undervoltage kept live and overvoltage silenced
    lfsr = nxt(lfsr);
    mask = (lfsr[15:0] & ~16'h0002) | 16'h0004;
    wrx(CMD_ALERT_MASK, mask, 2);
    rdx(CMD_ALERT_MASK, mask);
    cmp_in.undervoltage_enable_in = 1'b0;
    cyc(6);
    chk(16'h0001, 16'({gate_on, power_good_out, alert_oe}));
    cmp_in.undervoltage_enable_in = 1'b1;
    cyc(6);
    chk(16'h0007, 16'({gate_on, power_good_out, alert_oe}));
    rdx(CMD_INPUT, 16'h0010);
    rdx(CMD_SUMMARY, 16'h2000);
    rdx(CMD_DIAG, 16'h2008);
    clr();
    cmp_in.overvoltage_in = 1'b1;
    cyc(6);
    chk(16'h0000, 16'({gate_on, power_good_out, alert_oe}));
    rdx(CMD_SUMMARY, 16'h2800);
    cmp_in.overvoltage_in = 1'b0;
    cyc(6);
    chk(16'h0006, 16'({gate_on, power_good_out, alert_oe}));
    rdx(CMD_INPUT, 16'h0080);
    rdx(CMD_DIAG, 16'h1008);
    wrx(CMD_ALERT_MASK, 16'h0000, 2);
    clr();
    cmp_in.breaker_trip = 1'b1;
    cyc(6);
    chk(16'h0003, 16'({fast_turn_off, alert_oe}));
    cmp_in.breaker_trip = 1'b0;
    cyc(6);
    chk(16'h0005, 16'({gate_on, fast_turn_off, alert_oe}));
    rdx(CMD_MISC, 16'h0002);
    rdx(CMD_VENDOR, 16'h0010);
    rdx(CMD_DIAG, 16'h0088);
    clr();
    for (int k = 0; k < 2; k++) begin
      lim(1'b1, k);
      chk(16'h0001, 16'(timer_run));
      lim(1'b0, k);
      chk(16'h0002, 16'({gate_on, alert_oe}));
      rdx(CMD_INPUT, 16'h0000);
      lim(1'b1, k);
      cmp_in.timer_top = 1'b1;
      cyc(6);
      chk(16'h0001, 16'({gate_on, alert_oe}));
      cmp_in.timer_top = 1'b0;
      lim(1'b0, k);
      chk(16'h0001, 16'({gate_on, alert_oe}));
      rdx(CMD_INPUT, 16'h0004);
      rdx(CMD_DIAG, 16'h0828);
      wrx(CMD_OPERATION, {8'h00, OP_OFF}, 1);
      wrx(CMD_OPERATION, {8'h00, OP_ON}, 1);
      chk(16'h0002, 16'({gate_on, alert_oe}));
      rdx(CMD_INPUT, 16'h0000);
    end
    lfsr = nxt(lfsr);
    tval = 16'h0014 + 16'(lfsr[5:0]);
    cyc(2 * TP);
    rdx(CMD_TEMP, tval);
    tval = 16'h007E;
    cyc(2 * TP);
    chk(16'h0003, 16'({gate_on, alert_oe}));
    tval = 16'h0097;
    cyc(2 * TP);
    tval = 16'h001E;
    cyc(2 * TP);
    chk(16'h0001, 16'({gate_on, alert_oe}));
    rdx(CMD_DIAG, 16'h0308);
    clr();
    chk(16'h0002, 16'({gate_on, alert_oe}));
    wrx(CMD_OT_WARN, 16'h0014, 2);
    cyc(2 * TP);
    chk(16'h0003, 16'({gate_on, alert_oe}));
    wrx(CMD_OT_FAULT, 16'h001D, 2);
    cyc(2 * TP);
    chk(16'h0001, 16'({gate_on, alert_oe}));
    final_report();
  end
endmodule
bind hsf_fault_status hsf_fault_status_properties #(.TEMP_PERIOD(TEMP_PERIOD))
  i_hsf_fault_status_properties (.sys_clk, .rst_n, .cmp_in, .sda_in, .sda_out, .alert_out,
  .alert_oe, .temp_start, .gate_on, .fast_turn_off, .timer_run, .power_good_out);

//--- verif/hsf_host_model.sv
module hsf_host_model
  import hsf_pkg::*;
(
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda_wire
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves an eighth of a bit after the clock falls, never with it
  task automatic bit_io(input logic b, output logic r);
    #50 sda_low = !b;
    #150 scl = 1'b1;
    #100 r = sda_wire;
    #100 scl = 1'b0;
  endtask
  task automatic start();
    #50 sda_low = 1'b0;
    #150 scl = 1'b1;
    #200 sda_low = 1'b1;
    #200 scl = 1'b0;
  endtask
  task automatic stop();
    #50 sda_low = 1'b1;
    #150 scl = 1'b1;
    #200 sda_low = 1'b0;
    #200;
  endtask
  task automatic tx(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic rx(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int nb, output logic ok);
    logic a0, a1, a2, a3;
    start();
    tx({SLAVE_ADDR, 1'b0}, a0);
    tx(c, a1);
    a2 = 1'b1;
    a3 = 1'b1;
    if (nb > 0) tx(d[7:0], a2);
    if (nb > 1) tx(d[15:8], a3);
    stop();
    ok = a0 && a1 && a2 && a3;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    tx({SLAVE_ADDR, 1'b0}, a0);
    tx(c, a1);
    start();
    tx({SLAVE_ADDR, 1'b1}, a2);
    rx(1'b0, d[7:0]);
    rx(1'b1, d[15:8]);
    stop();
    ok = a0 && a1 && a2;
  endtask
endmodule
